// File: adc_ctrl_top.sv
// register bank, sequencer and result path of the dual converter
//
// Summary of operation
// [RULE_01] dac code is 10 bits, full code 2.5 V
// [RULE_02] data word captured at store strobe rising
// [RULE_03] configuration word 12 bits, zero after reset
// [RULE_04] fixed configuration field layout
// [RULE_05] channel code routes inputs to both converters
// [RULE_06] updates allowed only when update field 01; soft reset 101 here acts with any update field
// [RULE_07] deep sleep bit enters deep power-down
// [RULE_08] doze bit enters nap power-down
// [RULE_09] auto doze bit enables automatic nap
// [RULE_10] reference off bit disables internal reference
// [RULE_11] selector picks dac, sequencer or soft reset
// [RULE_12] power-down takes effect at store strobe
// [RULE_13] dac and sequencer applied after second write
// [RULE_14] input selection changes at store strobe
// [RULE_15] trigger converts channel selected before it
// [RULE_16] output register loaded when busy falls
// [RULE_17] results are 12-bit two's complement
// [RULE_18] sequencer armed by 01/100, next word loads
// [RULE_19] fixed sequencer field layout
// [RULE_20] sequencer mode sets trigger and busy grouping
// [RULE_21] length field enables zero to three slots
// [RULE_22] slot selects use channel code encoding
// [RULE_23] position reports next slot, zero if off
// [RULE_24] host sends dac code on bits 9:0
// [RULE_25] armed dac read drives code on 9:0
// [RULE_26] selector 101 resets whole block
// [RULE_27] disabled updates never arm second access
`timescale 1ns/100ps
module adc_ctrl_top
  import adc_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [11:0] host_data_in,
  output logic [11:0] host_data_out,
  output logic host_data_oe_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic sample_trigger,
  input wire logic [11:0] conv_a_raw,
  input wire logic [11:0] conv_b_raw,
  output logic busy,
  output logic [1:0] channel_code,
  output logic [1:0] mux_pos_sel,
  output logic mux_neg_pair1,
  output logic deep_sleep_en,
  output logic doze_en,
  output logic auto_doze_en,
  output logic auto_doze_active,
  output logic reference_off,
  output logic [9:0] ref_dac_code
);

  // ------------------------------------------------------------
  // state of the block
  // ------------------------------------------------------------
  typedef struct packed {
    logic [11:0] cfg;
    logic [9:0] dac;
    logic [9:0] seq;
    logic [1:0] pos;
    access_t acc;
    logic seq_run;
    logic gap;
    logic [1:0] cur_slot;
    logic [2:0][23:0] hold;
    logic [2:0][23:0] outr;
    logic [1:0] nres;
    logic [1:0] nout;
    logic [2:0] rd_idx;
    logic [11:0] dout;
    logic busy_q;
    logic napping;
  } state_t;

  localparam state_t ST_RST = '{
    cfg: CFG_RST,
    dac: DAC_RST,
    seq: SEQ_RST,
    pos: POS_RST,
    acc: ACC_IDLE,
    seq_run: 1'b0,
    gap: 1'b0,
    cur_slot: 2'h0,
    hold: '0,
    outr: '0,
    nres: 2'h0,
    nout: 2'h0,
    rd_idx: 3'h0,
    dout: 12'h000,
    busy_q: 1'b0,
    napping: 1'b0
  };

  state_t r;
  state_t r_nxt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // straight binary from the converter core to two's complement
  function automatic logic [11:0] to_twos(input logic [11:0] raw);
    to_twos = {~raw[11], raw[10:0]}; // RULE_17
  endfunction : to_twos

  // channel code held by a sequencer slot, slot 1..3
  function automatic logic [1:0] slot_code(
    input logic [9:0] seq,
    input logic [1:0] slot
  );
    case (slot)
      2'h1: slot_code = seq[SLOT1_LSB +: 2]; // RULE_19
      2'h2: slot_code = seq[SLOT2_LSB +: 2];
      2'h3: slot_code = seq[SLOT3_LSB +: 2];
      default: slot_code = 2'h0;
    endcase
  endfunction : slot_code

  // ------------------------------------------------------------
  // pin synchronisers and conversion timer
  // ------------------------------------------------------------
  logic wr_rise;
  logic rd_lvl;
  logic rd_fall;
  logic trig_fall;
  logic start;
  logic wake;
  logic abort;
  logic running;
  logic done;

  pin_edge_sync u_wr (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin(wr_n),
    .level(),
    .rise(wr_rise),
    .fall()
  );

  pin_edge_sync u_rd (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin(rd_n),
    .level(rd_lvl),
    .rise(),
    .fall(rd_fall)
  );

  pin_edge_sync u_trig (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin(sample_trigger),
    .level(),
    .rise(),
    .fall(trig_fall)
  );

  conv_timer u_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .start(start),
    .wake(wake),
    .abort(abort),
    .running(running),
    .done(done)
  );

  // ------------------------------------------------------------
  // decoded fields
  // ------------------------------------------------------------
  logic [1:0] len;
  logic [1:0] mode;
  logic upd_ok;
  logic pd_stop;
  logic [2:0] sel_in;
  logic [1:0] slot_idx;
  logic [1:0] pos_next;

  assign len = r.seq[LEN_LSB +: 2]; // RULE_21
  assign mode = r.seq[MODE_LSB +: 2];
  assign sel_in = host_data_in[SEL_LSB +: 3];
  assign upd_ok = host_data_in[UPD_LSB +: 2] == UPD_ON; // RULE_06
  // deep sleep or doze stop any running conversion
  assign pd_stop = r.cfg[DEEP_BIT] | r.cfg[DOZE_BIT]; // RULE_07 RULE_08
  // per-trigger mode keeps only the latest result in entry 0
  assign slot_idx = (len == 2'h0 || !mode[1]) ? 2'h0
                                              : r.cur_slot - 2'h1;
  assign pos_next = (r.pos == len) ? 2'h1 : r.pos + 2'h1; // RULE_23

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    r_nxt = r;
    start = 1'b0;
    wake = 1'b0;
    abort = pd_stop;
    r_nxt.busy_q = busy;

    // host store strobe: configuration or armed second write
    if (wr_rise) begin // RULE_02
      case (r.acc)
        ACC_DAC_WR: begin
          r_nxt.dac = host_data_in[DAC_W-1:0]; // RULE_13 RULE_24
          r_nxt.acc = ACC_IDLE;
        end
        ACC_SEQ_WR: begin
          r_nxt.seq = host_data_in[DATA_W-1:SEQ_STORE_LSB]; // RULE_18
          r_nxt.pos = (host_data_in[9:8] == 2'h0) ? 2'h0 : 2'h1;
          r_nxt.seq_run = 1'b0;
          r_nxt.gap = 1'b0;
          r_nxt.acc = ACC_IDLE;
        end
        default: begin
          r_nxt.cfg = host_data_in; // RULE_03 RULE_04 RULE_12 RULE_14
          r_nxt.acc = ACC_IDLE;
          if (upd_ok) begin // RULE_27
            case (sel_in) // RULE_11
              SEL_DAC_WR: r_nxt.acc = ACC_DAC_WR;
              SEL_DAC_RD: r_nxt.acc = ACC_DAC_RD;
              SEL_SEQ_WR: r_nxt.acc = ACC_SEQ_WR; // RULE_18
              SEL_SEQ_RD: r_nxt.acc = ACC_SEQ_RD;
              default: r_nxt.acc = ACC_IDLE;
            endcase
          end
        end
      endcase
    end

    // host read strobe: armed register read or next result word
    if (rd_fall) begin
      case (r.acc)
        ACC_DAC_RD: begin
          r_nxt.dout = {2'h0, r.dac}; // RULE_25
          r_nxt.acc = ACC_IDLE;
        end
        ACC_SEQ_RD: begin
          r_nxt.dout = {r.seq, r.pos}; // RULE_23
          r_nxt.acc = ACC_IDLE;
        end
        default: begin
          // words alternate a then b, slot by slot
          if (r.rd_idx[0]) begin
            r_nxt.dout = r.outr[r.rd_idx[2:1]][11:0];
          end else begin
            r_nxt.dout = r.outr[r.rd_idx[2:1]][23:12];
          end
          if (r.rd_idx[2:1] + 2'h1 >= r.nout && r.rd_idx[0]) begin
            r_nxt.rd_idx = 3'h0;
          end else begin
            r_nxt.rd_idx = r.rd_idx + 3'h1;
          end
        end
      endcase
    end

    // trigger falling edge starts one conversion or a sequence
    if (trig_fall && !busy && !pd_stop && !r.gap) begin // RULE_15
      start = 1'b1;
      wake = r.cfg[AUTO_BIT]; // RULE_09
      r_nxt.napping = 1'b0;
      r_nxt.cur_slot = r.pos;
      r_nxt.seq_run = (len != 2'h0) && (mode == 2'h3); // RULE_20
    end else if (r.gap && !pd_stop) begin
      // mode 1x: next slot follows without a new trigger
      start = 1'b1;
      r_nxt.gap = 1'b0;
      r_nxt.cur_slot = r.pos;
    end

    // end of a conversion: keep result, step the position
    if (done) begin
      r_nxt.hold[slot_idx] = {to_twos(conv_a_raw), to_twos(conv_b_raw)};
      r_nxt.nres = slot_idx + 2'h1;
      r_nxt.napping = r.cfg[AUTO_BIT]; // RULE_09
      if (len != 2'h0) begin
        r_nxt.pos = pos_next; // RULE_23
        if (mode[1] && r.cur_slot != len) begin
          r_nxt.gap = 1'b1; // RULE_20
        end else begin
          r_nxt.seq_run = 1'b0;
        end
      end
    end

    // output register follows the falling edge of busy
    if (r.busy_q && !busy) begin // RULE_16
      r_nxt.outr = r.hold;
      r_nxt.nout = r.nres;
      r_nxt.rd_idx = 3'h0;
    end

    // power-down drops any sequence in progress
    if (pd_stop) begin // RULE_07 RULE_08
      r_nxt.seq_run = 1'b0;
      r_nxt.gap = 1'b0;
    end

    // soft reset returns every register to its reset value
    if (wr_rise && r.acc != ACC_DAC_WR && r.acc != ACC_SEQ_WR
        && sel_in == SEL_SRST) begin // RULE_26
      r_nxt = ST_RST;
      abort = 1'b1;
      start = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= ST_RST; // RULE_03
    end else begin
      r <= r_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // busy spans the whole sequence in mode 11, drops in mode 10 gaps
  assign busy = running | r.seq_run; // RULE_20

  // sequencer slot overrides the configuration channel code
  assign channel_code = (len == 2'h0) ? r.cfg[CH_LSB +: 2]
                                      : slot_code(r.seq, r.pos); // RULE_22
  // 00 pair0+, 01 pair1-, 10 pair1+ on positive; pair1- only for 11
  assign mux_pos_sel = (channel_code == 2'h3) ? 2'h2
                                              : channel_code; // RULE_05
  assign mux_neg_pair1 = channel_code == 2'h3; // RULE_05

  assign deep_sleep_en = r.cfg[DEEP_BIT]; // RULE_07
  assign doze_en = r.cfg[DOZE_BIT]; // RULE_08
  assign auto_doze_en = r.cfg[AUTO_BIT]; // RULE_09
  assign auto_doze_active = r.napping;
  assign reference_off = r.cfg[REFOFF_BIT]; // RULE_10
  assign ref_dac_code = r.dac; // RULE_01

  // data lines driven while the read strobe is low
  assign host_data_out = r.dout;
  assign host_data_oe_n = rd_lvl;

endmodule : adc_ctrl_top

// File: adc_ctrl_pkg.sv
// constants, field layout and types of the converter control block
package adc_ctrl_pkg;

  // ------------------------------------------------------------
  // widths and values after reset
  // ------------------------------------------------------------
  localparam int DATA_W = 12;
  localparam int DAC_W = 10;
  localparam logic [11:0] CFG_RST = 12'h000;
  localparam logic [9:0] DAC_RST = 10'h3ff;
  localparam logic [9:0] SEQ_RST = 10'h000;
  localparam logic [1:0] POS_RST = 2'h0;

  // ------------------------------------------------------------
  // configuration word fields
  // ------------------------------------------------------------
  localparam int CH_LSB = 10;
  localparam int UPD_LSB = 8;
  localparam int DEEP_BIT = 7;
  localparam int DOZE_BIT = 6;
  localparam int AUTO_BIT = 5;
  localparam int REFOFF_BIT = 4;
  localparam int SEL_LSB = 0;
  localparam logic [1:0] UPD_ON = 2'h1;
  localparam logic [2:0] SEL_DAC_WR = 3'h1;
  localparam logic [2:0] SEL_DAC_RD = 3'h3;
  localparam logic [2:0] SEL_SEQ_WR = 3'h4;
  localparam logic [2:0] SEL_SRST = 3'h5;
  localparam logic [2:0] SEL_SEQ_RD = 3'h6;

  // ------------------------------------------------------------
  // sequencer word fields (stored bits 11:2, position read only)
  // ------------------------------------------------------------
  localparam int SEQ_STORE_LSB = 2;
  localparam int MODE_LSB = 8;
  localparam int LEN_LSB = 6;
  localparam int SLOT1_LSB = 4;
  localparam int SLOT2_LSB = 2;
  localparam int SLOT3_LSB = 0;

  // ------------------------------------------------------------
  // conversion timing in core clock cycles
  // ------------------------------------------------------------
  localparam logic [4:0] CONV_CYCLES = 5'd13;
  localparam logic [4:0] WAKE_CYCLES = 5'd6;

  // pending second access after a configuration write
  typedef enum logic [4:0] {
    ACC_IDLE = 5'h01,
    ACC_DAC_WR = 5'h02,
    ACC_DAC_RD = 5'h04,
    ACC_SEQ_WR = 5'h08,
    ACC_SEQ_RD = 5'h10
  } access_t;

endpackage : adc_ctrl_pkg

// File: pin_edge_sync.sv
// two-flop synchroniser with edge detection for one strobe pin
`timescale 1ns/100ps
module pin_edge_sync
  import adc_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;

  sync_t r;
  sync_t r_nxt;

  // shift chain, first stage only feeds the second
  always_comb begin
    r_nxt = r;
    r_nxt.s1 = pin;
    r_nxt.s2 = r.s1;
    r_nxt.s3 = r.s2;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '1;
    end else begin
      r <= r_nxt;
    end
  end

  // edges seen on the synchronised stages only
  assign level = r.s2;
  assign rise = r.s2 & ~r.s3;
  assign fall = ~r.s2 & r.s3;

endmodule : pin_edge_sync

// File: conv_timer.sv
// conversion cycle counter with optional wake-up lead time
`timescale 1ns/100ps
module conv_timer
  import adc_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic wake,
  input wire logic abort,
  output logic running,
  output logic done
);

  typedef struct packed {
    logic [4:0] cnt;
    logic run;
  } tmr_t;

  tmr_t r;
  tmr_t r_nxt;

  // load, count down, stop on abort
  always_comb begin
    r_nxt = r;
    if (abort) begin
      r_nxt.run = 1'b0;
      r_nxt.cnt = 5'h00;
    end else if (start && !r.run) begin
      r_nxt.run = 1'b1;
      r_nxt.cnt = wake ? CONV_CYCLES + WAKE_CYCLES : CONV_CYCLES;
    end else if (r.run) begin
      r_nxt.cnt = r.cnt - 5'h01;
      if (r.cnt == 5'h01) begin
        r_nxt.run = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign running = r.run;
  assign done = r.run && !abort && (r.cnt == 5'h01);

endmodule : conv_timer

// File: adc_ctrl_checker.sv
// port assertions for the converter control block
`timescale 1ns/100ps
module adc_ctrl_checker
  import adc_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic host_data_oe_n,
  input wire logic busy,
  input wire logic [1:0] channel_code,
  input wire logic [1:0] mux_pos_sel,
  input wire logic mux_neg_pair1,
  input wire logic deep_sleep_en,
  input wire logic doze_en,
  input wire logic auto_doze_en,
  input wire logic auto_doze_active,
  input wire logic reference_off,
  input wire logic [9:0] ref_dac_code
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // state straight after reset release
  chk_reset_state: assert property (
    $rose(arst_n) |-> ref_dac_code == 10'h3ff && !deep_sleep_en
    && !doze_en && !auto_doze_en && !reference_off && !busy)
    else $error("wrong state after reset");
  // mux routing follows the channel code
  chk_mux_map: assert property (
    mux_neg_pair1 == (channel_code == 2'h3) &&
    mux_pos_sel == ((channel_code == 2'h3) ? 2'h2 : channel_code))
    else $error("mux routing does not match channel code");
  // settings only move shortly after a store strobe
  chk_power_on_store: assert property (
    $changed({deep_sleep_en, doze_en, auto_doze_en, reference_off})
    |-> !$past(wr_n, 2) || !$past(wr_n, 3) || !$past(wr_n, 4)
    || !$past(wr_n, 5))
    else $error("power bits changed without a store strobe");
  chk_dac_on_store: assert property (
    $changed(ref_dac_code) |-> !$past(wr_n, 2) || !$past(wr_n, 3)
    || !$past(wr_n, 4) || !$past(wr_n, 5))
    else $error("dac code changed without a store strobe");
  // a conversion keeps busy up for at least 13 cycles
  chk_busy_length: assert property (
    $rose(busy) |-> busy[*8] ##1 busy[*5])
    else $error("busy shorter than a conversion");
  // data lines driven only while the read strobe is low
  chk_read_drive: assert property (
    $fell(rd_n) ##1 !rd_n[*3] |-> !host_data_oe_n)
    else $error("device not driving during read");
  chk_read_release: assert property (
    rd_n[*4] |-> host_data_oe_n)
    else $error("device driving outside read");
  // no conversion while powered down
  chk_sleep_idle: assert property (
    ($past(deep_sleep_en) || $past(doze_en)) && (deep_sleep_en || doze_en)
    |-> !busy)
    else $error("busy while powered down");
  chk_auto_doze: assert property (
    $rose(auto_doze_active) |-> auto_doze_en && !busy)
    else $error("auto doze entered without enable");
endmodule : adc_ctrl_checker

// File: host_model.sv
// host controller model for the parallel bus and trigger
`timescale 1ns/100ps
module host_model
(
  input wire logic core_clk,
  input wire logic busy,
  input wire logic [11:0] host_data_out,
  input wire logic host_data_oe_n,
  output logic [11:0] bus,
  output logic wr_n,
  output logic rd_n,
  output logic sample_trigger
);
  logic [11:0] drv = 12'h000;
  int n_busy = 0; // cycles counted by the last convert
  // wire level: device word while it drives, else host word
  assign bus = host_data_oe_n ? drv : host_data_out;
  // idle strobes from time zero
  initial begin
    wr_n = 1'b1;
    rd_n = 1'b1;
    sample_trigger = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  // word held around the strobe rise, then scrambled
  task automatic write(input logic [11:0] w);
    drv = w;
    wr_n = 1'b0;
    step(4);
    wr_n = 1'b1;
    step(4);
    drv = ~w;
    step(4);
  endtask : write
  task automatic read(output logic [11:0] d);
    rd_n = 1'b0;
    step(4);
    d = bus;
    rd_n = 1'b1;
    step(4);
  endtask : read
  // trigger pulse, then bounded wait for busy to fall
  task automatic convert(output logic ok);
    int i;
    i = 0;
    sample_trigger = 1'b0;
    step(3);
    sample_trigger = 1'b1;
    while (busy !== 1'b1 && i < 10) begin
      step(1);
      i++;
    end
    while (busy !== 1'b0 && i < 80) begin
      step(1);
      i++;
    end
    n_busy = i;
    ok = (i < 10) || (i < 80 && i > 0 && busy === 1'b0 && i != 10);
    step(2); // results read only after busy fell
  endtask : convert
endmodule : host_model

// File: dual_adc_config_sequencer_regs_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
module dual_adc_config_sequencer_regs_bench;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] conv_a_raw = 12'h000;
  logic [11:0] conv_b_raw = 12'h000;
  logic [11:0] bus, dout, rd_val, rd_exp;
  logic oe_n, wr_n, rd_n, trig, busy, neg, deep, doze, aen, aact, refo, ok;
  logic [1:0] code, pos;
  logic [9:0] dac;
  logic [8:0] status;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  // config word beside expected {code, pos, neg, deep, doze, auto, ref}
  logic [20:0] rows [9] = '{{12'h000, 9'h000}, {12'h408, 9'h0a0},
    {12'h800, 9'h140}, {12'hc00, 9'h1d0}, {12'h010, 9'h001},
    {12'h020, 9'h002}, {12'h040, 9'h004}, {12'h3f7, 9'h00f},
    {12'h002, 9'h000}};
  logic [23:0] raws [2] = '{{12'h000, 12'hfff}, {12'h7ff, 12'h800}};
  assign status = {code, pos, neg, deep, doze, aen, refo};
  always #5 core_clk = ~core_clk;
  // free-running cycle count, source of varied raw words
  always @(posedge core_clk) cyc <= cyc + 1;
  adc_ctrl_top uut (.core_clk(core_clk), .arst_n(arst_n),
    .host_data_in(bus), .host_data_out(dout), .host_data_oe_n(oe_n),
    .wr_n(wr_n), .rd_n(rd_n), .sample_trigger(trig),
    .conv_a_raw(conv_a_raw), .conv_b_raw(conv_b_raw), .busy(busy),
    .channel_code(code), .mux_pos_sel(pos), .mux_neg_pair1(neg),
    .deep_sleep_en(deep), .doze_en(doze), .auto_doze_en(aen),
    .auto_doze_active(aact), .reference_off(refo), .ref_dac_code(dac));
  host_model h (.core_clk(core_clk), .busy(busy), .host_data_out(dout),
    .host_data_oe_n(oe_n), .bus(bus), .wr_n(wr_n), .rd_n(rd_n),
    .sample_trigger(trig));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // watchdog: whole run needs well under 2000 cycles
  initial begin
    #100000;
    n_fail++;
    stop_test;
  end
  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    check({2'h0, dac}, 12'h3ff);
    check({3'h0, status}, 12'h000);
    foreach (rows[i]) begin
      h.write(rows[i][20:9]);
      check({3'h0, status}, {3'h0, rows[i][8:0]});
    end
    h.write(12'h101);
    check({2'h0, dac}, 12'h3ff);
    h.write(12'h1fd);
    check({2'h0, dac}, 12'h1fd);
    h.write(12'h103);
    h.read(rd_val);
    check(rd_val, 12'h1fd);
    // selector with updates off must not arm the dac
    h.write(12'h001);
    h.write(12'h000);
    check({2'h0, dac}, 12'h1fd);
    foreach (raws[i]) begin
      conv_a_raw = raws[i][23:12];
      conv_b_raw = raws[i][11:0];
      h.convert(ok);
      check({11'h0, ok}, 12'h001);
      check(12'(h.n_busy), 12'(adc_ctrl_pkg::CONV_CYCLES));
      h.read(rd_val);
      check(rd_val, raws[i][23:12] ^ 12'h800);
      h.read(rd_val);
      check(rd_val, raws[i][11:0] ^ 12'h800);
    end
    h.write(12'h020);
    h.convert(ok);
    check({11'h0, aact}, 12'h001);
    rd_exp = 12'(adc_ctrl_pkg::CONV_CYCLES + adc_ctrl_pkg::WAKE_CYCLES);
    check(12'(h.n_busy), rd_exp);
    // sequencer: three slots, codes 10, 01, 11
    h.write(12'h104);
    h.write(12'h39c);
    check({10'h0, code}, 12'h002);
    h.write(12'h106);
    h.read(rd_val);
    check(rd_val, 12'h39d);
    h.convert(ok);
    check({10'h0, code}, 12'h001);
    // mode 10, two slots: one trigger, a busy pulse per slot
    h.write(12'h104);
    h.write(12'ha90);
    h.convert(ok);
    check(12'(h.n_busy), 12'(adc_ctrl_pkg::CONV_CYCLES));
    check({11'h0, busy}, 12'h001);
    h.step(20);
    check({10'h0, code}, 12'h002);
    // mode 11, three slots: one busy, six result words then wrap
    conv_a_raw = cyc[11:0];
    conv_b_raw = ~cyc[11:0];
    h.write(12'h104);
    h.write(12'hf9c);
    h.convert(ok);
    check(12'(h.n_busy), 12'(3 * adc_ctrl_pkg::CONV_CYCLES + 2));
    for (int k = 0; k < 7; k++) begin
      h.read(rd_val);
      rd_exp = k[0] ? conv_b_raw : conv_a_raw;
      check(rd_val, rd_exp ^ 12'h800);
    end
    check({10'h0, code}, 12'h002);
    h.write(12'h080);
    h.convert(ok);
    check({11'h0, ok}, 12'h000);
    h.write(12'h005);
    check({2'h0, dac}, 12'h3ff);
    check({3'h0, status}, 12'h000);
    h.write(12'h106);
    h.read(rd_val);
    check(rd_val, 12'h000);
    // async reset in mid-run returns the dac to full code
    h.write(12'h101);
    h.write(12'h0cd);
    check({2'h0, dac}, 12'h0cd);
    arst_n = 1'b0;
    h.step(3);
    arst_n = 1'b1;
    check({2'h0, dac}, 12'h3ff);
    check({3'h0, status}, 12'h000);
    stop_test;
  end
endmodule : dual_adc_config_sequencer_regs_bench

bind adc_ctrl_top adc_ctrl_checker chk (.core_clk(core_clk),
  .arst_n(arst_n), .wr_n(wr_n), .rd_n(rd_n),
  .host_data_oe_n(host_data_oe_n), .busy(busy),
  .channel_code(channel_code), .mux_pos_sel(mux_pos_sel),
  .mux_neg_pair1(mux_neg_pair1), .deep_sleep_en(deep_sleep_en),
  .doze_en(doze_en), .auto_doze_en(auto_doze_en),
  .auto_doze_active(auto_doze_active), .reference_off(reference_off),
  .ref_dac_code(ref_dac_code));
